// File: dv/rtu_core_model.sv
// rtu_core_model: core-side pc, w and irq control fed by unit updates.
// assumes the update pulses last one cycle.
`timescale 1ns/1ps
module rtu_core_model
  import rtu_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic                 i_irq_clr,
  input  wire rtu_pkg::rtu_upd_t    i_upd,
  output logic [rtu_pkg::PC_W-1:0]  o_pc,
  output logic [rtu_pkg::LIT_W-1:0] o_w,
  output logic [7:0]                o_irq_ctrl
);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || i_irq_clr) o_irq_ctrl <= 8'h00;
    else o_irq_ctrl <= o_irq_ctrl | i_upd.irq_set_mask;
    if (i_upd.pc_load) o_pc <= i_upd.pc;
    if (i_upd.w_load) o_w <= i_upd.w;
  end
endmodule // rtu_core_model

// File: dv/rtu_return_unit_assertions.sv
// rtu_ret_checker: timing and content of return updates.
// assumes only the top module's ports are visible.
`timescale 1ns/1ps
module rtu_ret_checker
  import rtu_pkg::*;
(
  input wire logic                     i_clk_sys,
  input wire logic                     i_srst,
  input wire rtu_pkg::rtu_req_t        i_req,
  input wire logic                     i_call_push,
  input wire logic [rtu_pkg::PC_W-1:0] i_call_addr,
  input wire rtu_pkg::rtu_upd_t        o_upd,
  input wire logic                     o_busy,
  input wire logic                     o_done,
  input wire logic [3:0]               o_stack_ptr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // own idle tracking, kept apart from o_busy so a broken busy flop still trips
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       take;
  assign take = i_req.valid && (i_req.kind != RTU_NO_RETURN) && (cnt_q == 2'h0);
  assign cnt_d = take ? 2'h2 : ((cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0);
  always_ff @(posedge i_clk_sys)
    cnt_q <= i_srst ? 2'h0 : cnt_d;
  sequence s_busy_win;
    !o_busy ##1 o_busy[*2] ##1 !o_busy;
  endsequence
  sequence s_finish;
    !o_done[*2] ##1 (o_done && o_upd.pc_load);
  endsequence
  a_busy_two_cyc: assert property (take |-> s_busy_win)
    else $error("busy window wrong");
  a_done_latency: assert property (take |-> ##1 s_finish)
    else $error("done latency wrong");
  a_irq_enable_set: assert property (take && i_req.kind == RTU_IRQ_RETURN
    |-> ##3 o_upd.irq_set_mask == GLOBAL_IRQ_MASK) else $error("irq enable not set");
  a_mask_other_zero: assert property (take && i_req.kind != RTU_IRQ_RETURN
    |-> ##3 o_upd.irq_set_mask == IRQ_MASK_NONE) else $error("stray irq mask");
  a_literal_to_w: assert property (take && i_req.kind == RTU_LIT_RETURN
    |-> ##3 o_upd.w_load && o_upd.w == $past(i_req.literal, 3)) else $error("w wrong");
  a_w_lit_only: assert property (take && i_req.kind != RTU_LIT_RETURN
    |-> ##3 !o_upd.w_load) else $error("stray w load");
  a_pop_ptr_back: assert property (take
    |-> ##3 o_stack_ptr == $past(o_stack_ptr, 1) - STK_PTR_ONE) else $error("pop ptr");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done not a pulse");
endmodule // rtu_ret_checker
bind rtu_return_unit rtu_ret_checker u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .i_req(i_req), .i_call_push(i_call_push), .i_call_addr(i_call_addr), .o_upd(o_upd),
  .o_busy(o_busy), .o_done(o_done), .o_stack_ptr(o_stack_ptr));

// File: dv/rtu_return_unit_tb.sv
// rtu_return_unit_tb: random pushes and returns against a stack model.
// assumes the fixed three-edge answer latency of the unit after acceptance.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module rtu_return_unit_tb;
  import rtu_pkg::*;
  logic            clk = 0;
  logic            srst;
  rtu_req_t        req;
  logic            push;
  logic            irq_clr;
  logic [PC_W-1:0] addr;
  rtu_upd_t        upd;
  logic            busy;
  logic            done;
  logic [3:0]      sp;
  logic [3:0]      ptr;
  logic [PC_W-1:0] stk [16];
  logic [PC_W-1:0] pc;
  logic [7:0]      w;
  logic [7:0]      irqc;
  int              mismatches = 0;
  int              samples_checked = 0;
  always #25 clk = ~clk;
  rtu_return_unit DUT (.i_clk_sys(clk), .i_srst(srst), .i_req(req), .i_call_push(push),
    .i_call_addr(addr), .o_upd(upd), .o_busy(busy), .o_done(done), .o_stack_ptr(sp));
  rtu_core_model u_core (.i_clk_sys(clk), .i_srst(srst), .i_irq_clr(irq_clr), .i_upd(upd),
    .o_pc(pc), .o_w(w), .o_irq_ctrl(irqc));
  function automatic logic [7:0] exp_mask(input rtu_kind_t k);
    return (k == RTU_IRQ_RETURN) ? GLOBAL_IRQ_MASK : IRQ_MASK_NONE;
  endfunction
  task automatic pushes(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      push = 1;
      addr = 15'($urandom);
      ptr++;
      stk[ptr] = addr;
    end
    @(negedge clk);
    push = 0;
    @(negedge clk);
    `CHK("push_ptr", ptr, sp)
  endtask
  // junk: a second request and a push while busy, both must be dropped
  task automatic ret(input rtu_kind_t k, input logic [7:0] lit, input bit junk);
    logic [PC_W-1:0] epc;
    bit              go;
    go = (k != RTU_NO_RETURN);
    epc = stk[ptr];
    @(negedge clk);
    irq_clr = 1;
    req = '{1'b1, k, lit};
    @(negedge clk);
    irq_clr = 0;
    req.valid = 0;
    `CHK("busy", go, busy)
    @(negedge clk);
    if (junk && go)
    begin
      req = '{1'b1, k, ~lit};
      push = 1;
    end
    @(negedge clk);
    req.valid = 0;
    push = 0;
    if (go) ptr--;
    `CHK("busy_end", 1'b0, busy)
    `CHK("done", go, done)
    `CHK("ptr", ptr, sp)
    `CHK("mask", go ? exp_mask(k) : 8'h00, upd.irq_set_mask)
    if (go) `CHK("pc", epc, upd.pc)
    @(negedge clk);
    if (go) `CHK("core_pc", epc, pc)
    if (k == RTU_LIT_RETURN) `CHK("core_w", lit, w)
    `CHK("gie", go && k == RTU_IRQ_RETURN, irqc[GLOBAL_IRQ_BIT])
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    srst = 1;
    req = '0;
    push = 0;
    irq_clr = 0;
    addr = '0;
    ptr = 4'hf;
    void'($urandom(85027));
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 0;
    `CHK("sp_rst", 4'hf, sp)
    pushes(18);
    for (int k = 0; k < 4; k++) ret(rtu_kind_t'(k), 8'hff, 1);
    ret(RTU_LIT_RETURN, 8'h00, 0);
    repeat (40)
      if ($urandom % 2) pushes(1 + $urandom % 2);
      else ret(rtu_kind_t'($urandom % 4), 8'($urandom), 1'($urandom));
    give_verdict();
  end
endmodule // rtu_return_unit_tb

// File: rtl/rtu_return_unit.sv
// rtu_return_unit: executes the three return instructions of the core.
// assumes one clock per instruction cycle and that decode holds off while busy.
//
// Overview of operation
// - interrupt return pops stack into PC, two cycles
// - interrupt return sets global irq enable bit 7
// - subroutine return pops stack into PC, two cycles
// - literal return loads 8-bit immediate into W
// - literal return pops stack into PC, two cycles
`timescale 1ns/1ps
module rtu_return_unit
  import rtu_pkg::*;
(
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_srst,
  input  wire rtu_pkg::rtu_req_t          i_req,
  input  wire logic                       i_call_push,
  input  wire logic [rtu_pkg::PC_W-1:0]   i_call_addr,
  output rtu_pkg::rtu_upd_t               o_upd,
  output logic                            o_busy,
  output logic                            o_done,
  output logic [rtu_pkg::STK_PTR_W-1:0]   o_stack_ptr
);

  import rtu_pkg::*;

  rtu_state_t           state_q;
  rtu_state_t           state_d;
  rtu_kind_t            kind_q;
  rtu_kind_t            kind_d;
  logic [LIT_W-1:0]     lit_q;
  logic [LIT_W-1:0]     lit_d;
  logic [PC_W-1:0]      ret_addr_q;
  logic [PC_W-1:0]      ret_addr_d;
  rtu_upd_t             upd_q;
  rtu_upd_t             upd_d;
  logic                 busy_q;
  logic                 busy_d;
  logic                 done_q;
  logic                 done_d;
  logic [STK_PTR_W-1:0] ptr_q;

  logic [PC_W-1:0]      stack_top_entry;
  logic [STK_PTR_W-1:0] stack_ptr;
  logic                 req_is_return;
  logic                 accept;
  logic                 pop;
  logic                 push;
  logic                 in_idle;
  logic                 in_pop;
  logic                 in_load;
  logic                 kind_sets_irq;
  logic                 kind_loads_w;

  // a return opcode is any kind other than the no-return code
  function automatic logic is_return(input rtu_kind_t k);
    is_return = (k == RTU_SUB_RETURN) || (k == RTU_IRQ_RETURN) || (k == RTU_LIT_RETURN);
  endfunction

  assign in_idle       = (state_q == RTU_ST_IDLE);
  assign in_pop        = (state_q == RTU_ST_POP);
  assign in_load       = (state_q == RTU_ST_LOAD);
  assign req_is_return = i_req.valid && is_return(i_req.kind);

  // requests during either cycle of a return (POP or LOAD) are dropped, not queued
  assign accept        = in_idle && req_is_return;

  // the pop happens in the first instruction cycle
  assign pop           = in_pop;

  // calls from the core are only honoured while no return is in flight
  assign push          = i_call_push && in_idle;

  assign kind_sets_irq = (kind_q == RTU_IRQ_RETURN);
  assign kind_loads_w  = (kind_q == RTU_LIT_RETURN);

  rtu_stack u_stack (
    .i_clk_sys         (i_clk_sys),
    .i_srst            (i_srst),
    .i_push            (push),
    .i_push_addr       (i_call_addr),
    .i_pop             (pop),
    .o_stack_top_entry (stack_top_entry),
    .o_ptr             (stack_ptr)
  );

  // two instruction cycles: POP then LOAD, back to IDLE after LOAD
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RTU_ST_IDLE:
      begin
        if (accept)
        begin
          state_d = RTU_ST_POP;
        end
      end
      RTU_ST_POP:
      begin
        state_d = RTU_ST_LOAD;
      end
      RTU_ST_LOAD:
      begin
        state_d = RTU_ST_IDLE;
      end
      default:
      begin
        state_d = RTU_ST_IDLE;
      end
    endcase
  end

  // capture the instruction at acceptance so decode may move on
  assign kind_d     = accept ? i_req.kind : kind_q;
  assign lit_d      = accept ? i_req.literal : lit_q;

  // the popped address is the entry on top when the pop is issued
  assign ret_addr_d = pop ? stack_top_entry : ret_addr_q;

  assign busy_d     = (state_d != RTU_ST_IDLE);
  assign done_d     = in_load;

  // all updates land together at the end of the second cycle
  always_comb
  begin
    upd_d = UPD_RST;
    upd_d.pc = upd_q.pc;
    upd_d.w  = upd_q.w;
    if (in_load)
    begin
      upd_d.pc_load = 1'b1;
      upd_d.pc      = ret_addr_q;
      if (kind_loads_w)
      begin
        upd_d.w_load = 1'b1;
        upd_d.w      = lit_q;
      end
      if (kind_sets_irq)
      begin
        upd_d.irq_set_mask = GLOBAL_IRQ_MASK;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_q <= RTU_ST_IDLE;
      kind_q  <= RTU_NO_RETURN;
      lit_q   <= LIT_RST;
    end
    else
    begin
      state_q <= state_d;
      kind_q  <= kind_d;
      lit_q   <= lit_d;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ret_addr_q <= PC_RST;
      upd_q      <= UPD_RST;
    end
    else
    begin
      ret_addr_q <= ret_addr_d;
      upd_q      <= upd_d;
    end
  end

  // status outputs registered so every top output comes from a flop
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ptr_q  <= STK_PTR_RST;
    end
    else
    begin
      busy_q <= busy_d;
      done_q <= done_d;
      ptr_q  <= stack_ptr;
    end
  end

  assign o_upd       = upd_q;
  assign o_busy      = busy_q;
  assign o_done      = done_q;
  // pointer view lags the stack by one clock
  assign o_stack_ptr = ptr_q;

endmodule // rtu_return_unit

// File: rtl/rtu_stack.sv
// rtu_stack: circular return-address stack, one entry pushed or popped a cycle.
// assumes the caller never pushes and pops in the same cycle; pop wins if it does.
`timescale 1ns/1ps
module rtu_stack
  import rtu_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic                 i_push,
  input  wire logic [PC_W-1:0]      i_push_addr,
  input  wire logic                 i_pop,
  output logic      [PC_W-1:0]      o_stack_top_entry,
  output logic      [STK_PTR_W-1:0] o_ptr
);

  logic [PC_W-1:0]      mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_q;
  logic [STK_PTR_W-1:0] ptr_d;
  logic [STK_PTR_W-1:0] ptr_inc;
  logic [STK_PTR_W-1:0] ptr_dec;
  logic                 do_push;

  // overflow and underflow simply wrap, as a circular hardware stack does
  assign ptr_inc           = ptr_q + STK_PTR_ONE;
  assign ptr_dec           = ptr_q - STK_PTR_ONE;
  assign do_push           = i_push && !i_pop;
  assign ptr_d             = i_pop ? ptr_dec : (do_push ? ptr_inc : ptr_q);
  assign o_stack_top_entry = mem[ptr_q];
  assign o_ptr             = ptr_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ptr_q <= STK_PTR_RST;
    end
    else
    begin
      ptr_q <= ptr_d;
    end
  end

  // entries are not cleared by reset; only the pointer is
  always_ff @(posedge i_clk_sys)
  begin
    if (do_push)
    begin
      mem[ptr_inc] <= i_push_addr;
    end
  end

endmodule // rtu_stack

// File: shared/rtu_pkg.sv
// rtu_pkg: constants and carrier types for the return instruction unit.
// assumes one core clock edge per instruction cycle.
package rtu_pkg;

  // program counter and return stack geometry
  localparam int unsigned PC_W       = 15;
  localparam int unsigned STK_DEPTH  = 16;
  localparam int unsigned STK_PTR_W  = 4;
  localparam int unsigned LIT_W      = 8;

  // stack pointer reset value: one below entry 0, so the first push lands in 0
  localparam logic [STK_PTR_W-1:0] STK_PTR_RST = 4'hf;
  localparam logic [STK_PTR_W-1:0] STK_PTR_ONE = 4'h1;

  // interrupt control register: global enable position
  localparam int unsigned IRQ_CTRL_W      = 8;
  localparam int unsigned GLOBAL_IRQ_BIT  = 7;
  localparam logic [IRQ_CTRL_W-1:0] GLOBAL_IRQ_MASK = 8'h80;
  localparam logic [IRQ_CTRL_W-1:0] IRQ_MASK_NONE   = 8'h00;

  // every return instruction lasts this many instruction cycles
  localparam int unsigned RET_CYCLES = 2;

  localparam logic [PC_W-1:0]  PC_RST  = 15'h0000;
  localparam logic [LIT_W-1:0] LIT_RST = 8'h00;

  typedef enum logic [1:0] {
    RTU_SUB_RETURN = 2'b00,
    RTU_IRQ_RETURN = 2'b01,
    RTU_LIT_RETURN = 2'b10,
    RTU_NO_RETURN  = 2'b11
  } rtu_kind_t;

  typedef enum logic [1:0] {
    RTU_ST_IDLE = 2'b00,
    RTU_ST_POP  = 2'b01,
    RTU_ST_LOAD = 2'b10
  } rtu_state_t;

  // request from the instruction decode stage
  typedef struct packed {
    logic              valid;
    rtu_kind_t         kind;
    logic [LIT_W-1:0]  literal;
  } rtu_req_t;

  // updates to program counter, working register and interrupt control
  typedef struct packed {
    logic                   pc_load;
    logic [PC_W-1:0]        pc;
    logic                   w_load;
    logic [LIT_W-1:0]       w;
    logic [IRQ_CTRL_W-1:0]  irq_set_mask;
  } rtu_upd_t;

  localparam rtu_upd_t UPD_RST = '{
    pc_load:      1'b0,
    pc:           PC_RST,
    w_load:       1'b0,
    w:            LIT_RST,
    irq_set_mask: IRQ_MASK_NONE
  };

endpackage : rtu_pkg
